/* File: hdl/dbs_cfg.svh */
// Constants for the bus-sharing transfer controller
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH
`define DBS_AW          20
`define DBS_DW          16
`define DBS_SZW         16
`define DBS_BURST_WIN   4'hA
`define DBS_BURST_DMA   4'h8
`define DBS_QUIET_CYC   2'h3
`define DBS_LOW16_MASK  20'h0FFFF
`define DBS_MODE_SINGLE 2'h0
`define DBS_MODE_BLOCK  2'h1
`define DBS_MODE_BURST  2'h2
`endif

/* File: hdl/dbs_pkg.sv */
// Types for the bus-sharing transfer controller
package dbs_pkg;
	typedef enum logic [1:0] {DBS_IDLE, DBS_READ, DBS_WRITE} dbs_state_t;
endpackage

/* File: hdl/dbs_buf2.sv */
// Two-entry valid/ready buffer for transfer data
`timescale 1ns/1ps
module dbs_buf2 #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem [2];   // Storage
	logic         wp, rp;    // Pointers
	logic [1:0]   cnt;       // Fill level
	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;
	assign in_ready  = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign out_data  = mem[rp];
	// Pointer and level update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) wp <= ~wp;
			if (pop) rp <= ~rp;
			cnt <= cnt + {1'b0, push} - {1'b0, pop};
		end
	end
	// Data store, no reset needed
	always_ff @(posedge clk) begin
		if (push) mem[wp] <= in_data;
	end
endmodule

/* File: hdl/dbs_areg.sv */
// Guarded 20-bit channel address register
`timescale 1ns/1ps
`include "dbs_cfg.svh"
module dbs_areg (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Software write
	input  wire logic                 wr_full,
	input  wire logic                 wr_word,
	input  wire logic [`DBS_AW-1:0]   wr_data,
	// Controller advance
	input  wire logic                 step,
	input  wire logic [`DBS_AW-1:0]   step_val,
	// Value
	output logic [`DBS_AW-1:0]        q
);
	// Software write beats the controller step in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) q <= '0;
		else if (wr_full) q <= wr_data;                 // see RULE4
		else if (wr_word) q <= wr_data & `DBS_LOW16_MASK; // see RULE5
		else if (step) q <= step_val;
	end
endmodule

/* File: hdl/dbs_ctrl.sv */
// Transfer channel with bus sharing and halt handover
`timescale 1ns/1ps
`include "dbs_cfg.svh"
// How it works
// RULE1: Repeat mode reloads size, restarts unless disabled
// RULE2: Burst block gives eight of ten cycles
// RULE3: Halt allowed after three quiet cycles, idle core
// RULE4: Address write never torn by a transfer
// RULE5: Word write loads only low sixteen bits
// RULE6: Software sets hold-off or disables before access
// RULE7: No transfer during core flag read-modify-write
// RULE8: No stack write during risky stack instructions
// RULE9: Never access a peripheral asserting wait
// RULE10: Channel wins at boundary, returns bus promptly
module dbs_ctrl #(
	parameter int SZW = `DBS_SZW
) (
	// Clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RESETN,
	// Channel configuration
	input  wire logic               CHANNEL_ENABLE,
	input  wire logic               REPEAT_MODE,
	input  wire logic [1:0]         XFER_MODE,
	input  wire logic               RMW_HOLD_OFF,
	input  wire logic [SZW-1:0]     SIZE_LOAD,
	input  wire logic               TRIGGER,
	// Address register writes
	input  wire logic               SRC_WR_FULL,
	input  wire logic               SRC_WR_WORD,
	input  wire logic               DST_WR_FULL,
	input  wire logic               DST_WR_WORD,
	input  wire logic [`DBS_AW-1:0] ADDR_WDATA,
	// Core status
	input  wire logic               CPU_BUS_REQ,
	input  wire logic               CPU_BOUNDARY,
	input  wire logic               CPU_RMW_FLAG,
	input  wire logic               CPU_STACK_RISK,
	input  wire logic [`DBS_AW-1:0] STACK_LOW,
	// System bus
	input  wire logic               PERIPH_WAIT,
	input  wire logic [`DBS_DW-1:0] BUS_RDATA,
	// Outputs
	output logic                    BUS_GRANT,
	output logic                    BUS_RD,
	output logic                    BUS_WR,
	output logic [`DBS_AW-1:0]      BUS_ADDR,
	output logic [`DBS_DW-1:0]      BUS_WDATA,
	output logic                    HALT_OK,
	output logic                    BUSY,
	output logic [SZW-1:0]          TRANSFER_SIZE_COUNTER,
	output logic [`DBS_AW-1:0]      CHANNEL_SOURCE_ADDRESS,
	output logic [`DBS_AW-1:0]      CHANNEL_DESTINATION_ADDRESS
);
	//----------------------------------------
	// State
	//----------------------------------------
	dbs_pkg::dbs_state_t state, next_state; // Transfer phase
	logic [SZW-1:0] size_cnt;   // Remaining words
	logic           active;     // Block in progress
	logic [3:0]     win_cnt;    // Burst window position
	logic [1:0]     quiet;      // Cycles since last request
	logic           req_q;      // Registered request
	logic [`DBS_AW-1:0] src, dst; // Address values
	logic           buf_in_rdy, buf_out_vld;
	logic [`DBS_DW-1:0] buf_out;

	//----------------------------------------
	// Decode
	//----------------------------------------
	// Any software touch of address registers blocks transfers
	wire addr_wr  = SRC_WR_FULL | SRC_WR_WORD | DST_WR_FULL | DST_WR_WORD;
	// Burst mode leaves the last two window slots to the core
	wire in_dma_slot = (XFER_MODE != `DBS_MODE_BURST) ||
		(win_cnt < `DBS_BURST_DMA);                       // see RULE2
	// Stack writes wait out the risky stack instructions
	wire stack_hit = (dst >= STACK_LOW) & CPU_STACK_RISK;  // see RULE8
	// Conditions under which the bus may be touched at all
	wire safe      = CPU_BOUNDARY & ~CPU_RMW_FLAG & ~addr_wr
		& ~PERIPH_WAIT & ~RMW_HOLD_OFF;            // see RULE4 RULE7 RULE9
	// Request: block running, enabled and inside a slot
	wire want      = active & CHANNEL_ENABLE & in_dma_slot;
	// Accesses only in the controller's own slots, never when disabled
	wire do_read   = (state == dbs_pkg::DBS_READ) & safe & buf_in_rdy
		& want;                                     // see RULE2
	wire do_write  = (state == dbs_pkg::DBS_WRITE) & safe & buf_out_vld
		& want & ~stack_hit;                        // see RULE2 RULE8
	// A word read by a cancelled block is thrown away, never written
	wire drop      = ~active & buf_out_vld;
	// Final word of the block
	wire last      = do_write & (size_cnt == {{(SZW-1){1'b0}}, 1'b1});
	// The request towards the core side is the want term itself
	wire bus_req   = want;                              // see RULE10
	// Address steps, one word each
	wire [`DBS_AW-1:0] src_inc = src + 20'h00001;
	wire [`DBS_AW-1:0] dst_inc = dst + 20'h00001;

	//----------------------------------------
	// Address registers
	//----------------------------------------
	dbs_areg u_src (
		.clk(CLOCK), .rst_n(RESETN),
		.wr_full(SRC_WR_FULL), .wr_word(SRC_WR_WORD),
		.wr_data(ADDR_WDATA), .step(do_read), .step_val(src_inc),
		.q(src)
	);
	dbs_areg u_dst (
		.clk(CLOCK), .rst_n(RESETN),
		.wr_full(DST_WR_FULL), .wr_word(DST_WR_WORD),
		.wr_data(ADDR_WDATA), .step(do_write), .step_val(dst_inc),
		.q(dst)
	);

	//----------------------------------------
	// Data buffer
	//----------------------------------------
	// Holds at most one word, since reads and writes alternate
	dbs_buf2 #(.W(`DBS_DW)) u_buf (
		.clk(CLOCK), .rst_n(RESETN),
		.in_valid(do_read), .in_ready(buf_in_rdy), .in_data(BUS_RDATA),
		.out_valid(buf_out_vld), .out_ready(do_write | drop),
		.out_data(buf_out)
	);

	//----------------------------------------
	// Next state
	//----------------------------------------
	// Read and write alternate, one word at a time
	always_comb begin
		next_state = state;
		case (state)
			dbs_pkg::DBS_IDLE:  if (want) next_state = dbs_pkg::DBS_READ;
			dbs_pkg::DBS_READ:  begin
				if (!want) next_state = dbs_pkg::DBS_IDLE;
				else if (do_read) next_state = dbs_pkg::DBS_WRITE;
			end
			dbs_pkg::DBS_WRITE: begin
				if (!active) next_state = dbs_pkg::DBS_IDLE;
				else if (do_write) next_state = want ? dbs_pkg::DBS_READ
					: dbs_pkg::DBS_IDLE;
			end
			default: next_state = dbs_pkg::DBS_IDLE;
		endcase
	end

	//----------------------------------------
	// Sequencing
	//----------------------------------------
	// Block start, size count, repeat reload
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state    <= dbs_pkg::DBS_IDLE;
			size_cnt <= '0;
			active   <= 1'b0;
		end else begin
			state <= next_state;
			// Disabling cancels the block at once
			if (!CHANNEL_ENABLE) active <= 1'b0;
			// Last word: reload, carry on only in repeat mode
			else if (last) begin
				size_cnt <= SIZE_LOAD;                   // see RULE1
				active   <= REPEAT_MODE;                 // see RULE1
			end else if (!active && TRIGGER) begin
				size_cnt <= SIZE_LOAD;
				active   <= (SIZE_LOAD != '0);
			end else if (do_write)
				size_cnt <= size_cnt - {{(SZW-1){1'b0}}, 1'b1};
		end
	end

	// Burst window: eight controller slots then two core slots
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) win_cnt <= 4'h0;
		else if (XFER_MODE != `DBS_MODE_BURST || !active) win_cnt <= 4'h0;
		else if (win_cnt == `DBS_BURST_WIN - 4'h1) win_cnt <= 4'h0; // see RULE2
		else win_cnt <= win_cnt + 4'h1;
	end

	// Quiet counter for debug halt handover
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			quiet <= 2'h0;
			req_q <= 1'b0;
		end else begin
			req_q <= bus_req;
			if (bus_req) quiet <= 2'h0;
			else if (quiet != `DBS_QUIET_CYC) quiet <= quiet + 2'h1; // see RULE3
		end
	end

	// Registered bus outputs
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			BUS_GRANT <= 1'b0;
			BUS_RD    <= 1'b0;
			BUS_WR    <= 1'b0;
			BUS_ADDR  <= '0;
			BUS_WDATA <= '0;
			HALT_OK   <= 1'b0;
			BUSY      <= 1'b0;
			TRANSFER_SIZE_COUNTER       <= '0;
			CHANNEL_SOURCE_ADDRESS      <= '0;
			CHANNEL_DESTINATION_ADDRESS <= '0;
		end else begin
			// Grant follows the request at core boundaries, whatever the other safe terms
			BUS_GRANT <= bus_req & CPU_BOUNDARY;        // see RULE10
			BUS_RD    <= do_read;
			BUS_WR    <= do_write;
			BUS_ADDR  <= do_write ? dst : src;
			BUS_WDATA <= buf_out;
			// Halt permit after three quiet cycles and an idle core
			HALT_OK   <= (quiet == `DBS_QUIET_CYC) & ~bus_req
				& ~CPU_BUS_REQ;                          // see RULE3
			// State views for software, one cycle late
			BUSY      <= active;
			TRANSFER_SIZE_COUNTER       <= size_cnt;
			CHANNEL_SOURCE_ADDRESS      <= src;
			CHANNEL_DESTINATION_ADDRESS <= dst;
		end
	end

	//----------------------------------------
	// Checks
	//----------------------------------------
	// Access gating
	a_no_wait_access: assert property ( // see RULE9
		@(posedge CLOCK) disable iff (!RESETN)
		PERIPH_WAIT |=> !BUS_RD && !BUS_WR)
		else $error("access during wait");
	a_no_rmw_xfer: assert property ( // see RULE7
		@(posedge CLOCK) disable iff (!RESETN)
		CPU_RMW_FLAG |=> !BUS_RD && !BUS_WR)
		else $error("access during flag rmw");
	a_holdoff_block: assert property ( // see RULE6
		@(posedge CLOCK) disable iff (!RESETN)
		RMW_HOLD_OFF |=> !BUS_RD && !BUS_WR)
		else $error("access during hold-off");
	a_addr_wr_block: assert property ( // see RULE4
		@(posedge CLOCK) disable iff (!RESETN)
		addr_wr |=> !BUS_RD && !BUS_WR)
		else $error("access during address write");
	a_boundary_only: assert property ( // see RULE10
		@(posedge CLOCK) disable iff (!RESETN)
		!CPU_BOUNDARY |=> !BUS_RD && !BUS_WR)
		else $error("access away from a boundary");
	a_off_no_access: assert property ( // see RULE1
		@(posedge CLOCK) disable iff (!RESETN)
		!CHANNEL_ENABLE |=> !BUS_RD && !BUS_WR)
		else $error("access while disabled");
	a_burst_gap: assert property ( // see RULE2
		@(posedge CLOCK) disable iff (!RESETN)
		(XFER_MODE == `DBS_MODE_BURST && win_cnt >= `DBS_BURST_DMA)
		|=> !BUS_RD && !BUS_WR)
		else $error("burst used core slot");
	a_stack_safe: assert property ( // see RULE8
		@(posedge CLOCK) disable iff (!RESETN)
		stack_hit |=> !BUS_WR)
		else $error("stack write in risky instr");
	a_grant_drop: assert property ( // see RULE10
		@(posedge CLOCK) disable iff (!RESETN)
		!bus_req |=> !BUS_GRANT)
		else $error("bus kept after requests");
	// Halt handover
	a_halt_quiet: assert property ( // see RULE3
		@(posedge CLOCK) disable iff (!RESETN)
		HALT_OK |-> !$past(req_q) && !$past(CPU_BUS_REQ))
		else $error("halt while bus busy");
	a_halt_after3: assert property ( // see RULE3
		@(posedge CLOCK) disable iff (!RESETN)
		req_q |-> ##1 !HALT_OK ##1 !HALT_OK)
		else $error("halt too early");
	a_halt_core: assert property ( // see RULE3
		@(posedge CLOCK) disable iff (!RESETN)
		CPU_BUS_REQ |=> !HALT_OK)
		else $error("halt while core wants bus");
	a_halt_no_access: assert property ( // see RULE3
		@(posedge CLOCK) disable iff (!RESETN)
		HALT_OK |-> !BUS_RD && !BUS_WR)
		else $error("halt during an access");
	// Block sequencing
	a_repeat_reload: assert property ( // see RULE1
		@(posedge CLOCK) disable iff (!RESETN)
		(last && CHANNEL_ENABLE) |=> size_cnt == $past(SIZE_LOAD)
		&& active == $past(REPEAT_MODE))
		else $error("repeat reload wrong");
	a_trigger_load: assert property ( // see RULE1
		@(posedge CLOCK) disable iff (!RESETN)
		(TRIGGER && CHANNEL_ENABLE && !active)
		|=> size_cnt == $past(SIZE_LOAD))
		else $error("size not loaded at start");
	// Address registers
	a_word_low16: assert property ( // see RULE5
		@(posedge CLOCK) disable iff (!RESETN)
		(SRC_WR_WORD && !SRC_WR_FULL) |=> src[19:16] == 4'h0)
		else $error("word write above 64K");
	a_full_intact: assert property ( // see RULE4
		@(posedge CLOCK) disable iff (!RESETN)
		DST_WR_FULL |=> dst == $past(ADDR_WDATA))
		else $error("address write torn");
	// Scenarios worth seeing
	c_repeat: cover property (@(posedge CLOCK) last && REPEAT_MODE);
	c_burst: cover property (@(posedge CLOCK)
		XFER_MODE == `DBS_MODE_BURST && win_cnt == 4'h9);
	c_halt: cover property (@(posedge CLOCK) HALT_OK);
	c_stack_wait: cover property (@(posedge CLOCK) stack_hit && buf_out_vld);
	c_cancel: cover property (@(posedge CLOCK) drop);
endmodule

/* File: test/dbs_core_model.sv */
// Model of the core and wait-state peripherals on the shared bus
`timescale 1ns/1ps
module dbs_core_model (
	// Scenario controls
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic        want,
	// Core and peripheral status
	output logic             bus_req,
	output logic             boundary,
	output logic             rmw_flag,
	output logic             stack_risk,
	output logic             wait_st,
	output logic [15:0]      rdata
);
	int seed = 39617; // Own fixed seed

	// Benign until the bench asks for stalls
	initial begin
		{bus_req, rmw_flag, stack_risk, wait_st} = 4'h0;
		boundary = 1'b1;
		rdata = 16'h0000;
	end

	// New values just after each falling edge
	always @(negedge clk) begin
		bus_req    <= want;
		boundary   <= !stall || ($random(seed) % 2 != 0);
		rmw_flag   <= stall && ($random(seed) % 4 == 0);
		stack_risk <= stall && ($random(seed) % 2 != 0);
		wait_st    <= stall && ($random(seed) % 4 == 0);
		rdata      <= 16'($random(seed)); // Changes every cycle
	end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the bus-sharing transfer controller
`timescale 1ns/1ps
`include "dbs_cfg.svh"
module tb_top;
	// Design inputs
	logic        clk = 0, rst_n = 0, en = 0, rep = 0, hold = 0, trig = 0;
	logic [1:0]  mode = 0;
	logic [15:0] size = 0;
	logic        sfull = 0, sword = 0, dfull = 0, dword = 0;
	logic [19:0] wdat = 0, stk = 20'hFFFFF;
	logic        stall = 0, want = 0;
	// Partner and design outputs
	logic        req, bnd, rmw, srisk, pw, gnt, brd, bwr, hok, busy;
	logic [15:0] rd, wd, cnt;
	logic [19:0] ba, sa, da;
	// Bench state
	int          n_fail = 0, tests_run = 0, seed = 39617, n_wr = 0, k, m;
	logic [19:0] xs, xd;
	logic [15:0] xdat, p_rd;
	logic [9:0]  hist = 0;
	logic [1:0]  quiet = 0;
	logic        chk_a = 1, p_ok = 1, p_stk = 0, p_req = 0;

	always #25 clk = ~clk;

	dbs_core_model u_core (.clk(clk), .stall(stall), .want(want),
		.bus_req(req), .boundary(bnd), .rmw_flag(rmw), .stack_risk(srisk),
		.wait_st(pw), .rdata(rd));
	dbs_ctrl u_dut (.CLOCK(clk), .RESETN(rst_n), .CHANNEL_ENABLE(en),
		.REPEAT_MODE(rep), .XFER_MODE(mode), .RMW_HOLD_OFF(hold),
		.SIZE_LOAD(size), .TRIGGER(trig), .SRC_WR_FULL(sfull),
		.SRC_WR_WORD(sword), .DST_WR_FULL(dfull), .DST_WR_WORD(dword),
		.ADDR_WDATA(wdat), .CPU_BUS_REQ(req), .CPU_BOUNDARY(bnd),
		.CPU_RMW_FLAG(rmw), .CPU_STACK_RISK(srisk), .STACK_LOW(stk),
		.PERIPH_WAIT(pw), .BUS_RDATA(rd), .BUS_GRANT(gnt), .BUS_RD(brd),
		.BUS_WR(bwr), .BUS_ADDR(ba), .BUS_WDATA(wd), .HALT_OK(hok),
		.BUSY(busy), .TRANSFER_SIZE_COUNTER(cnt),
		.CHANNEL_SOURCE_ADDRESS(sa), .CHANNEL_DESTINATION_ADDRESS(da));

	// Compare one value, count and report
	task automatic cmp(input string what, input logic [19:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Full writes of both address registers
	task automatic ld(input logic [19:0] s, d);
		wdat = s; sfull = 1; tick(1); sfull = 0;
		wdat = d; dfull = 1; tick(1); dfull = 0; tick(2);
		cmp("src reg", s, sa);
		cmp("dst reg", d, da);
		xs = s; xd = d; n_wr = 0; chk_a = 1;
	endtask

	task automatic start(input logic [1:0] md, input logic [15:0] n,
			input logic r);
		mode = md; size = n; rep = r; en = 1; trig = 1; tick(1); trig = 0;
	endtask

	// Bounded wait for a number of written words
	task automatic wait_wr(input int n, input bit exact);
		int t;
		for (t = 0; t < 3000 && n_wr < n; t++) tick(1);
		tick(6);
		if (exact) cmp("words", 20'(n), 20'(n_wr));
		else cmp("words", 1, n_wr >= n);
	endtask

	// Each access against the conditions of its deciding edge
	always @(posedge clk) begin
		if (brd) begin
			cmp("safe read", 1, p_ok);
			if (chk_a) cmp("read addr", xs, ba);
			xs <= xs + 20'h1;
			xdat <= p_rd;
		end
		if (bwr) begin
			cmp("safe write", 1, p_ok);
			cmp("stack write", 0, p_stk && ba >= stk);
			if (chk_a) cmp("write addr", xd, ba);
			cmp("write data", xdat, wd);
			xd <= xd + 20'h1;
			n_wr <= n_wr + 1;
		end
		if (hok) cmp("halt quiet", 0, {quiet, brd | bwr, p_req});
		if (mode == `DBS_MODE_BURST)
			cmp("burst share", 1, $countones(hist) <= 8);
		hist <= {hist[8:0], brd | bwr};
		quiet <= {quiet[0], brd | bwr};
		p_ok <= !pw && !rmw && !hold && bnd && !(sfull | sword | dfull | dword);
		p_stk <= srisk;
		p_rd <= rd;
		p_req <= req;
	end

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Cut a hang short
	initial begin
		#(50 * 80000);
		n_fail++;
		conclude();
	end

	initial begin
		tick(2); rst_n = 1; tick(1);
		// Word writes keep only the low sixteen bits
		wdat = 20'hABCDE; sword = 1; dword = 1; tick(1);
		sword = 0; dword = 0; tick(2);
		cmp("src word", wdat & `DBS_LOW16_MASK, sa);
		cmp("dst word", wdat & `DBS_LOW16_MASK, da);
		// Random blocks in all modes, odd ones with a stalling core
		for (k = 0; k < 12; k++) begin
			stall = k[0];
			stk = k[0] ? 20'h01004 : 20'hFFFFF;
			ld(20'($random(seed)), 20'h01000);
			m = (k % 3 == 0) ? 1 : $unsigned($random(seed)) % 12 + 1;
			start(2'(k % 3), 16'(m), 0);
			wait_wr(m, 1);
			stall = 0; tick(8);
			cmp("halt ok", 1, hok);
			cmp("bus freed", 0, gnt);
			want = 1; tick(3);
			cmp("halt core", 0, hok);
			want = 0;
		end
		// Hold-off blocks every access until released
		hold = 1; ld(20'h00300, 20'h02000); start(1, 4, 0); tick(20);
		cmp("held words", 0, 20'(n_wr));
		cmp("held size", 4, 20'(cnt));
		cmp("held grant", 1, gnt);
		hold = 0; wait_wr(4, 1);
		// Repeat mode reloads until disabled
		ld(20'h00400, 20'h03000); start(2, 3, 1); wait_wr(7, 0);
		en = 0; tick(8); m = n_wr; tick(20);
		cmp("stopped", 20'(m), 20'(n_wr));
		cmp("idle", 0, busy);
		// Full address write in mid-block stays whole
		ld(20'h00200, 20'h01000); start(1, 12, 0); wait_wr(3, 0);
		chk_a = 0; wdat = 20'h52000; dfull = 1; tick(1); dfull = 0;
		wait_wr(12, 0);
		cmp("dst upper", 20'h5, 20'(da[19:16]));
		conclude();
	end
endmodule
